// ==== dram_thermal_throttle_tb.sv ====
`timescale 1ns/1ps
module dram_thermal_throttle_tb
   import dtt_pkg::*;
;
   localparam int STEP = 10;
   logic                      clk = 1'b0;
   logic                      rstn;
   logic [ADDR_W-1:0]         reg_addr;
   logic [31:0]               reg_wdata;
   logic                      reg_wr;
   logic                      reg_rd;
   logic [31:0]               reg_rdata;
   logic [NUM_DIMM-1:0]       act_issued;
   logic [NUM_DIMM-1:0]       cmd_issued;
   logic                      throttle_active;
   logic                      cmd_block;
   logic [NUM_DIMM-1:0]       want_act;
   logic [NUM_DIMM-1:0]       want_cmd;
   logic [NUM_DIMM-1:0][15:0] n_issued;
   int                        n_errors = 0;
   int                        comparisons = 0;

   always #4 clk = ~clk;

   dtt_top #(.STEP_CYC(STEP)) dtt_top_inst (
      .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .act_issued(act_issued), .cmd_issued(cmd_issued),
      .throttle_active(throttle_active), .cmd_block(cmd_block));
   dtt_sched_model dtt_sched_model_inst (
      .clk(clk), .rstn(rstn), .want_act(want_act), .want_cmd(want_cmd),
      .cmd_block(cmd_block), .act_issued(act_issued),
      .cmd_issued(cmd_issued), .n_issued(n_issued));

   // ------------------------------------------------------------
   // Bus and helper tasks
   // ------------------------------------------------------------
   task automatic conclude;
      if (n_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, e, reg_rdata);
   endtask
   function automatic logic [31:0] mk_low(logic [1:0] s, logic [5:0] d,
                                          logic [7:0] g);
      return {1'b1, 1'b0, s, 14'h0000, d, g};
   endfunction
   // Enable goes in last so that every field is settled first.
   task automatic cfg(input logic [31:0] lo, input logic [31:0] hi,
                      input logic [31:0] th);
      wr(OFS_CTRL_LOW, 32'h0000_0000);
      wr(OFS_THRESH, th);
      wr(OFS_CTRL_HIGH, hi);
      wr(OFS_CTRL_LOW, lo);
      repeat (2) @(posedge clk);
   endtask
   task automatic pulse(input logic [3:0] a, input logic [3:0] c, input int n);
      @(posedge clk);
      want_act <= a;
      want_cmd <= c;
      repeat (n) @(posedge clk);
      want_act <= 4'h0;
      want_cmd <= 4'h0;
   endtask
   // The first look waits one step, so an edge that just launched the
   // level is seen and the count runs from that edge.
   task automatic wsig(input bit blk, input logic v, input int lim,
                       output int n);
      n = 0;
      #1;
      while (((blk ? cmd_block : throttle_active) !== v) && n < lim)
      begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rchk("ctrl_low", OFS_CTRL_LOW, RST_CTRL_LOW);
      rchk("ctrl_high", OFS_CTRL_HIGH, RST_CTRL_HIGH);
      rchk("threshold", OFS_THRESH, RST_THRESH);
      wr(OFS_STATUS, 32'hFFFF_FFFF);
      rchk("status", OFS_STATUS, 32'h0000_0000);
      rchk("unmapped", 8'h40, 32'h0000_0000);
   endtask
   task automatic t_weights;
      int wa[4] = '{1, 3, 2, 3};
      int wc[4] = '{1, 2, 1, 1};
      for (int s = 0; s < 4; s++)
      begin
         cfg(mk_low(2'(s), 6'h00, 8'hFF), 32'h0000_FFFF, RST_THRESH);
         pulse(4'(1 << s), 4'(1 << s), 1);
         repeat (3) @(posedge clk);
         rchk("count", OFS_DIMM_CNT + 8'(4 * s), 32'(wa[s] + wc[s]));
         rchk("other", OFS_DIMM_CNT + 8'(4 * ((s + 1) % 4)), 32'h0);
      end
   endtask
   task automatic t_cross;
      int n;
      cfg(mk_low(2'b01, 6'h02, 8'h02), 32'h0000_FFFF, 32'h0000_0005);
      rchk("ctrl_low", OFS_CTRL_LOW, mk_low(2'b01, 6'h02, 8'h02));
      pulse(4'h8, 4'h8, 1);
      wsig(1'b0, 1'b1, 8, n);
      chk("equal not crossing", 32'h0, 32'(throttle_active));
      // A fresh start drops the old count, so the crossing edge is known.
      cfg(mk_low(2'b01, 6'h02, 8'h02), 32'h0000_FFFF, 32'h0000_0004);
      pulse(4'h8, 4'h8, 2);
      wsig(1'b0, 1'b1, 8, n);
      chk("throttle", 32'h1, 32'(throttle_active));
      wsig(1'b0, 1'b0, 100, n);
      chk("throttle length", 32'(1 + 2 * 2 * STEP), 32'(n));
      pulse(4'h8, 4'h8, 2);
      wsig(1'b0, 1'b1, 8, n);
      chk("rearmed", 32'h1, 32'(throttle_active));
      @(posedge clk);
      rstn <= 1'b0;
      #1;
      chk("reset ends throttle", 32'h0, 32'(throttle_active));
      @(posedge clk);
      rstn <= 1'b1;
   endtask
   task automatic t_block;
      int n;
      logic [15:0] b1;
      logic [15:0] b2;
      cfg(mk_low(2'b00, 6'h03, 8'h01), 32'h0010_0002, 32'h0000_0000);
      pulse(4'h1, 4'h0, 2);
      wsig(1'b0, 1'b1, 8, n);
      chk("throttle all", 32'h1, 32'(throttle_active));
      b1 = n_issued[1];
      b2 = n_issued[2];
      @(posedge clk);
      want_act <= 4'h6;
      wsig(1'b1, 1'b1, 8, n);
      chk("dimm1 per window", 32'h2, 32'(n_issued[1] - b1));
      chk("dimm2 per window", 32'h2, 32'(n_issued[2] - b2));
      wsig(1'b1, 1'b0, 20, n);
      chk("block released", 32'h1, 32'(n < 20));
      wr(OFS_THRESH, RST_THRESH);
      wsig(1'b0, 1'b0, 60, n);
      b1 = n_issued[1];
      repeat (4) @(posedge clk);
      #1;
      chk("free traffic", 32'h4, 32'(n_issued[1] - b1));
      @(posedge clk);
      want_act <= 4'h0;
   endtask
   task automatic t_off;
      int n;
      for (int k = 0; k < 2; k++)
      begin
         cfg(k == 0 ? mk_low(2'b00, 6'h01, 8'h00)
                    : mk_low(2'b00, 6'h00, 8'h01), 32'h0000_FFFF, 32'h0);
         pulse(4'h4, 4'h4, 3);
         wsig(1'b0, 1'b1, 12, n);
         chk("throttle when off", 32'h0, 32'(throttle_active));
      end
   endtask

   initial
   begin
      rstn      = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      want_act  = 4'h0;
      want_cmd  = 4'h0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_weights();
      t_cross();
      t_block();
      t_off();
      conclude();
   end

   // The whole sequence needs well under two thousand cycles.
   initial
   begin
      repeat (6000) @(posedge clk);
      n_errors++;
      conclude();
   end
endmodule

// ==== dtt_act_cnt.sv ====
`timescale 1ns/1ps
module dtt_act_cnt
   import dtt_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   dtt_cnt_if.ctr   bus
);
   typedef struct packed {
      logic [NUM_DIMM-1:0][CNT_W-1:0] cnt;
   } dtt_cnt_st_t;

   dtt_cnt_st_t                    st_ff;
   dtt_cnt_st_t                    nxt_st;
   logic [NUM_DIMM-1:0][CNT_W-1:0] sum;

   for (genvar g = 0; g < NUM_DIMM; g++)
   begin : g_dimm
      logic [2:0]       incr;
      logic [CNT_W-1:0] base;
      logic [CNT_W:0]   add;
      // An event in the clearing cycle counts toward the new window.
      assign incr = (bus.act[g] ? {1'b0, bus.act_w} : 3'd0)
                  + (bus.cmd[g] ? {1'b0, bus.cmd_w} : 3'd0); // RULE6
      assign base = bus.clr ? '0 : st_ff.cnt[g]; // RULE15
      assign add  = {1'b0, base} + {{(CNT_W-2){1'b0}}, incr}; // RULE7
      assign sum[g] = add[CNT_W] ? '1 : add[CNT_W-1:0]; // RULE16
   end

   always_comb
   begin
      nxt_st     = st_ff;
      nxt_st.cnt = sum;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign bus.cnt = st_ff.cnt;
endmodule

// ==== dtt_cnt_if.sv ====
`timescale 1ns/1ps
interface dtt_cnt_if import dtt_pkg::*; ();
   logic [NUM_DIMM-1:0]            act;
   logic [NUM_DIMM-1:0]            cmd;
   logic                           clr;
   logic [1:0]                     act_w;
   logic [1:0]                     cmd_w;
   logic [NUM_DIMM-1:0][CNT_W-1:0] cnt;
   modport src (output act, output cmd, output clr, output act_w,
                output cmd_w, input cnt);
   modport ctr (input act, input cmd, input clr, input act_w,
                input cmd_w, output cnt);
endinterface

// ==== dtt_pkg.sv ====
// How it works
// RULE1 - Each DIMM's weighted activity per sample window meets one threshold; the code flags a crossing only when a count is above it, not equal to it.
// RULE2 - A crossing on any DIMM throttles every DIMM for the duration.
// RULE3 - When the duration ends, monitoring of sample windows resumes.
// RULE4 - Only one threshold register exists, shared by all DIMM slots.
// RULE5 - Firmware sets windows, duration and thresholds before enabling.
// RULE6 - Activates are weighted against read/write commands by bits 29:28.
// RULE7 - Threshold and counts are weighted numbers of active DDR clocks.
// RULE8 - With 3:2 weighting one activate plus one read costs five units.
// RULE9 - Sample window is set in 4 ms steps up to 1.02 s; zero disables.
// RULE10 - The sample window is measured in clock cycles of the memory clock.
// RULE11 - Throttle duration is a 6-bit count of sample windows.
// RULE12 - Outside throttling nothing is blocked; activity is only counted.
// RULE13 - While throttling, no DIMM may pass the maximum in a monitor window; blocking starts once a count has reached it, so a weighted count can pass it.
// RULE14 - Once a DIMM reaches the maximum, all commands block to window end.
// RULE15 - Counters clear at each window start; reset ends throttling.
// RULE16 - Activity counters saturate instead of wrapping.
package dtt_pkg;

   localparam int NUM_DIMM = 4;
   localparam int CNT_W    = 32;
   localparam int ADDR_W   = 8;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL_LOW  = 8'h00;
   localparam logic [7:0] OFS_CTRL_HIGH = 8'h04;
   localparam logic [7:0] OFS_THRESH    = 8'h08;
   localparam logic [7:0] OFS_STATUS    = 8'h0C;
   localparam logic [7:0] OFS_DIMM_CNT  = 8'h10;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int LOW_GSW_LSB  = 0;
   localparam int LOW_DUR_LSB  = 8;
   localparam int LOW_WSEL_LSB = 28;
   localparam int LOW_EN_BIT   = 31;
   localparam int HIGH_TAM_LSB = 0;
   localparam int HIGH_TMW_LSB = 16;
   localparam int ST_THR_BIT   = 0;
   localparam int ST_BLK_BIT   = 1;
   localparam int ST_LEFT_LSB  = 8;
   localparam logic [31:0] RST_CTRL_LOW  = 32'h0000_0000;
   localparam logic [31:0] RST_CTRL_HIGH = 32'h0000_0000;
   localparam logic [31:0] RST_THRESH    = 32'hFFFF_FFFF;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int GSW_STEP_US  = 4000;
   localparam int CLK_MHZ      = 125;
   localparam int DTT_STEP_CYC = GSW_STEP_US * CLK_MHZ;

   typedef enum logic [1:0] {
      DTT_IDLE = 2'b00,
      DTT_MON  = 2'b01,
      DTT_THR  = 2'b11
   } dtt_state_t;

   // Returns {activate weight, command weight}.
   function automatic logic [3:0] dtt_weights(input logic [1:0] sel);
      logic [3:0] w;
      w = 4'h5;
      case (sel)
         2'b00:   w = 4'h5;
         2'b01:   w = 4'hE;
         2'b10:   w = 4'h9;
         2'b11:   w = 4'hD;
         default: w = 4'h5;
      endcase
      return w;
   endfunction

endpackage

// ==== dtt_sched_model.sv ====
`timescale 1ns/1ps
module dtt_sched_model
   import dtt_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic [NUM_DIMM-1:0]   want_act,
   input  wire logic [NUM_DIMM-1:0]   want_cmd,
   input  wire logic                  cmd_block,
   output logic [NUM_DIMM-1:0]        act_issued,
   output logic [NUM_DIMM-1:0]        cmd_issued,
   output logic [NUM_DIMM-1:0][15:0]  n_issued
);
   // ------------------------------------------------------------
   // Scheduler
   // ------------------------------------------------------------
   // The block is honoured in the same cycle, as a real scheduler would.
   assign act_issued = cmd_block ? '0 : want_act;
   assign cmd_issued = cmd_block ? '0 : want_cmd;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         n_issued <= '0;
      else
         for (int i = 0; i < NUM_DIMM; i++)
            n_issued[i] <= n_issued[i] + 16'(act_issued[i])
                         + 16'(cmd_issued[i]);
   end
endmodule

// ==== dtt_top.sv ====
`timescale 1ns/1ps
module dtt_top
   import dtt_pkg::*;
#(
   parameter int STEP_CYC = DTT_STEP_CYC
) (
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [31:0]              reg_rdata,
   input  wire logic [NUM_DIMM-1:0] act_issued,
   input  wire logic [NUM_DIMM-1:0] cmd_issued,
   output logic                     throttle_active,
   output logic                     cmd_block
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] thermal_ctrl_low;
      logic [31:0] thermal_ctrl_high;
      logic [31:0] global_activity_threshold;
      logic [31:0] rdata;
      dtt_state_t  state;
      logic [7:0]  step_cnt;
      logic [5:0]  win_left;
      logic        blocked;
      logic        restart;
   } dtt_st_t;

   dtt_st_t st_ff;
   dtt_st_t nxt_st;

   // ----------------------------------------------------------------
   // Field views
   // ----------------------------------------------------------------
   logic        ctl_enable;
   logic [7:0]  global_sample_window;
   logic [5:0]  throttle_duration;
   logic [1:0]  weight_sel;
   logic [15:0] throttle_activity_max;
   logic [15:0] throttle_monitor_window;
   logic [3:0]  weights;

   assign ctl_enable           = st_ff.thermal_ctrl_low[LOW_EN_BIT];
   assign global_sample_window =
      st_ff.thermal_ctrl_low[LOW_GSW_LSB +: 8]; // RULE9
   assign throttle_duration    =
      st_ff.thermal_ctrl_low[LOW_DUR_LSB +: 6]; // RULE11
   assign weight_sel           =
      st_ff.thermal_ctrl_low[LOW_WSEL_LSB +: 2]; // RULE6
   assign throttle_activity_max   =
      st_ff.thermal_ctrl_high[HIGH_TAM_LSB +: 16];
   assign throttle_monitor_window =
      st_ff.thermal_ctrl_high[HIGH_TMW_LSB +: 16];
   assign weights = dtt_weights(weight_sel); // RULE8

   // ----------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------
   // The 4 ms step is counted in memory clocks, so its length follows
   // the clock rate; a long step keeps the sample window step count to 8 bits.
   logic step_tick;
   logic tmw_tick;
   logic step_restart;
   logic tmw_restart;
   logic window_end;

   assign step_restart = (st_ff.state == DTT_IDLE) || st_ff.restart;
   assign tmw_restart  = (st_ff.state != DTT_THR) || st_ff.restart;

   dtt_win_timer #(
      .W (32)
   ) u_step_tmr (
      .clk     (clk),
      .rstn    (rstn),
      .restart (step_restart),
      .len     (32'(STEP_CYC)), // RULE10
      .tick    (step_tick)
   );

   dtt_win_timer #(
      .W (16)
   ) u_tmw_tmr (
      .clk     (clk),
      .rstn    (rstn),
      .restart (tmw_restart),
      .len     (throttle_monitor_window),
      .tick    (tmw_tick)
   );

   assign window_end = step_tick &&
      (st_ff.step_cnt == global_sample_window - 8'd1); // RULE9

   // ----------------------------------------------------------------
   // Activity counters
   // ----------------------------------------------------------------
   dtt_cnt_if samp_if ();
   dtt_cnt_if thr_if ();

   assign samp_if.act   = act_issued;
   assign samp_if.cmd   = cmd_issued;
   assign samp_if.act_w = weights[3:2];
   assign samp_if.cmd_w = weights[1:0];
   assign samp_if.clr   = (st_ff.state != DTT_MON) || st_ff.restart
                        || window_end; // RULE15

   assign thr_if.act    = act_issued;
   assign thr_if.cmd    = cmd_issued;
   assign thr_if.act_w  = weights[3:2];
   assign thr_if.cmd_w  = weights[1:0];
   assign thr_if.clr    = tmw_restart || tmw_tick; // RULE15

   dtt_act_cnt u_samp_cnt (
      .clk  (clk),
      .rstn (rstn),
      .bus  (samp_if)
   );

   dtt_act_cnt u_thr_cnt (
      .clk  (clk),
      .rstn (rstn),
      .bus  (thr_if)
   );

   // ----------------------------------------------------------------
   // Threshold compare
   // ----------------------------------------------------------------
   logic [NUM_DIMM-1:0] over;
   logic [NUM_DIMM-1:0] reach;
   logic                crossing;
   logic                any_reach;

   for (genvar g = 0; g < NUM_DIMM; g++)
   begin : g_cmp
      // One shared threshold serves every slot.
      assign over[g]  = samp_if.cnt[g] >
                        st_ff.global_activity_threshold; // RULE1 RULE4
      assign reach[g] = thr_if.cnt[g] >=
                        {16'h0000, throttle_activity_max}; // RULE13
   end

   assign crossing  = (st_ff.state == DTT_MON) && !st_ff.restart
                    && (|over); // RULE2
   assign any_reach = (st_ff.state == DTT_THR) && !st_ff.restart
                    && (|reach); // RULE14

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   logic [ADDR_W-1:0] dimm_ofs;

   assign status_word = {18'h0_0000, st_ff.win_left, 6'h00,
                         st_ff.blocked, (st_ff.state == DTT_THR)};
   assign dimm_ofs    = reg_addr - OFS_DIMM_CNT;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (reg_addr)
         OFS_CTRL_LOW:  rd_mux = st_ff.thermal_ctrl_low;
         OFS_CTRL_HIGH: rd_mux = st_ff.thermal_ctrl_high;
         OFS_THRESH:    rd_mux = st_ff.global_activity_threshold;
         OFS_STATUS:    rd_mux = status_word;
         default:
         begin
            if ((reg_addr >= OFS_DIMM_CNT) && (dimm_ofs[1:0] == 2'b00)
                && (dimm_ofs[ADDR_W-1:2] < (ADDR_W-2)'(NUM_DIMM)))
               rd_mux = samp_if.cnt[dimm_ofs[3:2]];
            else
               rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st         = st_ff;
      nxt_st.restart = 1'b0;
      nxt_st.rdata   = reg_rd ? rd_mux : 32'h0000_0000;

      if (reg_wr)
      begin
         case (reg_addr)
            OFS_CTRL_LOW:  nxt_st.thermal_ctrl_low  = reg_wdata;
            OFS_CTRL_HIGH: nxt_st.thermal_ctrl_high = reg_wdata;
            OFS_THRESH:
               nxt_st.global_activity_threshold = reg_wdata; // RULE4
            default:       nxt_st.rdata = nxt_st.rdata;
         endcase
      end

      // Step counter within the current sample window.
      if (window_end || step_restart)
         nxt_st.step_cnt = 8'd0;
      else if (step_tick)
         nxt_st.step_cnt = st_ff.step_cnt + 8'd1;

      // Blocking holds until the monitor window ends; a new reach in
      // the ending cycle belongs to the old window and is dropped.
      if (tmw_restart || tmw_tick)
         nxt_st.blocked = 1'b0;
      else if (any_reach)
         nxt_st.blocked = 1'b1; // RULE14

      case (st_ff.state)
         DTT_IDLE:
         begin
            // Settings are taken as programmed before enable is set.
            if (ctl_enable && (global_sample_window != 8'd0)) // RULE5
            begin
               nxt_st.state   = DTT_MON;
               nxt_st.restart = 1'b1;
            end
         end
         DTT_MON:
         begin
            if (!ctl_enable || (global_sample_window == 8'd0)) // RULE9
               nxt_st.state = DTT_IDLE;
            else if (crossing && (throttle_duration != 6'd0))
            begin
               nxt_st.state    = DTT_THR; // RULE2
               nxt_st.win_left = throttle_duration; // RULE11
               nxt_st.restart  = 1'b1;
            end
            else if (crossing)
               nxt_st.restart = 1'b1;
         end
         DTT_THR:
         begin
            if (!ctl_enable || (global_sample_window == 8'd0))
            begin
               nxt_st.state    = DTT_IDLE;
               nxt_st.win_left = 6'd0;
               nxt_st.blocked  = 1'b0;
            end
            else if (window_end && (st_ff.win_left == 6'd1))
            begin
               nxt_st.state    = DTT_MON; // RULE3
               nxt_st.win_left = 6'd0;
               nxt_st.blocked  = 1'b0;
               nxt_st.restart  = 1'b1;
            end
            else if (window_end)
               nxt_st.win_left = st_ff.win_left - 6'd1; // RULE11
         end
         default:
         begin
            nxt_st.state    = DTT_IDLE;
            nxt_st.win_left = 6'd0;
            nxt_st.blocked  = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff.thermal_ctrl_low          <= RST_CTRL_LOW;
         st_ff.thermal_ctrl_high         <= RST_CTRL_HIGH;
         st_ff.global_activity_threshold <= RST_THRESH;
         st_ff.rdata                     <= 32'h0000_0000;
         st_ff.state                     <= DTT_IDLE; // RULE15
         st_ff.step_cnt                  <= 8'd0;
         st_ff.win_left                  <= 6'd0;
         st_ff.blocked                   <= 1'b0;
         st_ff.restart                   <= 1'b0;
      end
      else
         st_ff <= nxt_st;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata       = st_ff.rdata;
   assign throttle_active = (st_ff.state == DTT_THR);
   // Blocking only exists while throttling; monitoring never limits.
   assign cmd_block = throttle_active
                    && (st_ff.blocked || any_reach); // RULE12 RULE14
endmodule

// ==== dtt_top_assertions.sv ====
`timescale 1ns/1ps
module dtt_top_assertions
   import dtt_pkg::*;
#(
   parameter int STEP_CYC = DTT_STEP_CYC
) (
   input wire logic                clk,
   input wire logic                rstn,
   input wire logic [ADDR_W-1:0]   reg_addr,
   input wire logic [31:0]         reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [31:0]         reg_rdata,
   input wire logic [NUM_DIMM-1:0] act_issued,
   input wire logic [NUM_DIMM-1:0] cmd_issued,
   input wire logic                throttle_active,
   input wire logic                cmd_block
);
   // ------------------------------------------------------------
   // Register shadows
   // ------------------------------------------------------------
   // Shadows follow the bus alone, so the checks never lean on the body.
   logic [31:0] low_ff;
   logic [31:0] high_ff;
   logic [31:0] thr_ff;
   logic [31:0] len_ff;
   logic [31:0] exp_len;
   logic [7:0]  gsw;
   logic [5:0]  dur;
   assign gsw = low_ff[LOW_GSW_LSB +: 8];
   assign dur = low_ff[LOW_DUR_LSB +: 6];
   assign exp_len = 32'(1 + int'(dur) * int'(gsw) * STEP_CYC);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         low_ff  <= RST_CTRL_LOW;
         high_ff <= RST_CTRL_HIGH;
         thr_ff  <= RST_THRESH;
         len_ff  <= 32'h0000_0000;
      end
      else
      begin
         if (reg_wr && reg_addr == OFS_CTRL_LOW)
            low_ff <= reg_wdata;
         if (reg_wr && reg_addr == OFS_CTRL_HIGH)
            high_ff <= reg_wdata;
         if (reg_wr && reg_addr == OFS_THRESH)
            thr_ff <= reg_wdata;
         len_ff <= throttle_active ? len_ff + 32'h0000_0001 : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   idle_noblock_a: assert property (
      !throttle_active |-> !cmd_block)
      else $error("Commands blocked outside throttling.");
   status_thr_a: assert property (
      reg_rd && reg_addr == OFS_STATUS
      |=> reg_rdata[ST_THR_BIT] == $past(throttle_active))
      else $error("Status throttling bit disagrees with the port.");
   thresh_rb_a: assert property (
      reg_rd && reg_addr == OFS_THRESH |=> reg_rdata == $past(thr_ff))
      else $error("Shared threshold reads back wrong.");
   ctrl_rb_a: assert property (
      reg_rd && reg_addr == OFS_CTRL_LOW
      |=> (reg_rdata & 32'hB000_3FFF) == ($past(low_ff) & 32'hB000_3FFF))
      else $error("Low control word reads back wrong.");
   high_rb_a: assert property (
      reg_rd && reg_addr == OFS_CTRL_HIGH |=> reg_rdata == $past(high_ff))
      else $error("High control word reads back wrong.");
   off_quiet_a: assert property (
      !low_ff[LOW_EN_BIT] || gsw == 8'h00 |=> !throttle_active)
      else $error("Throttling while monitoring is off.");
   dur_len_a: assert property (
      $fell(throttle_active) && low_ff[LOW_EN_BIT] && gsw != 8'h00
      && $stable(low_ff) |-> len_ff == exp_len)
      else $error("Throttle duration has the wrong length.");
   rise_dur_a: assert property (
      $rose(throttle_active) |-> dur != 6'h00 && low_ff[LOW_EN_BIT])
      else $error("Throttling began without a duration.");
   reset_clear_a: assert property (
      $rose(rstn) |-> !throttle_active && !cmd_block)
      else $error("Throttling active after reset.");
endmodule

bind dtt_top dtt_top_assertions #(.STEP_CYC(STEP_CYC))
   dtt_top_assertions_inst (
   .clk(clk),
   .rstn(rstn),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .act_issued(act_issued),
   .cmd_issued(cmd_issued),
   .throttle_active(throttle_active),
   .cmd_block(cmd_block)
);

// ==== dtt_win_timer.sv ====
`timescale 1ns/1ps
module dtt_win_timer #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         restart,
   input  wire logic [W-1:0] len,
   output logic              tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } dtt_tmr_st_t;

   dtt_tmr_st_t st_ff;
   dtt_tmr_st_t nxt_st;

   // A length of zero stops the timer, so no window ever ends.
   assign tick = !restart && (len != '0) && (st_ff.cnt >= len - 1'b1);

   always_comb
   begin
      nxt_st = st_ff;
      if (restart || tick || (len == '0))
         nxt_st.cnt = '0;
      else
         nxt_st.cnt = st_ff.cnt + 1'b1;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
endmodule
